// ---- src/eis_pkg.sv ----
package eis_pkg;

    // Register offsets on the host bus (byte addresses)
    localparam logic [7:0] EIS_OFS_STATUS = 8'h58;
    localparam logic [7:0] EIS_OFS_ENABLE = 8'h5C;
    localparam logic [7:0] EIS_OFS_BYTE_TEST = 8'h64;
    localparam logic [7:0] EIS_OFS_FIFO_LEVEL = 8'h68;

    // Status bit positions
    localparam int EIS_BIT_SOFTWARE = 31;
    localparam int EIS_BIT_TX_HALTED = 25;
    localparam int EIS_BIT_RX_HALTED = 24;
    localparam int EIS_BIT_DROP_MID = 23;
    localparam int EIS_BIT_BUF_LOADED = 21;
    localparam int EIS_BIT_RX_DMA = 20;
    localparam int EIS_BIT_TIMER_WRAP = 19;
    localparam int EIS_BIT_TRANSCEIVER = 18;
    localparam int EIS_BIT_POWER = 17;
    localparam int EIS_BIT_TXS_OVERFLOW = 16;
    localparam int EIS_BIT_OVERSIZE = 15;
    localparam int EIS_BIT_RX_ERROR = 14;
    localparam int EIS_BIT_TX_ERROR = 13;
    localparam int EIS_BIT_TXD_OVERRUN = 10;
    localparam int EIS_BIT_TXD_AVAIL = 9;
    localparam int EIS_BIT_TXS_FULL = 8;
    localparam int EIS_BIT_TXS_LEVEL = 7;
    localparam int EIS_BIT_FRAME_DROP = 6;
    localparam int EIS_BIT_RXS_FULL = 4;
    localparam int EIS_BIT_RXS_LEVEL = 3;
    localparam int EIS_BIT_PIN_LSB = 0;
    localparam int EIS_PIN_COUNT = 3;

    // Implemented status bits, and the subset that a written one clears
    localparam logic [31:0] EIS_STATUS_MASK = 32'h83BF_E7DF;
    localparam logic [31:0] EIS_W1C_MASK = 32'h83BB_E7DF;
    localparam logic [31:0] EIS_ENABLE_MASK = 32'h83BF_E7DF;
    localparam logic [31:0] EIS_ZERO_WORD = 32'h0000_0000;

    // Level register layout and reset value
    localparam logic [31:0] EIS_FIFO_LEVEL_RESET = 32'h4800_0000;
    localparam logic [31:0] EIS_FIFO_LEVEL_MASK = 32'hFFFF_00FF;
    localparam int EIS_TXD_AVAIL_LSB = 24;
    localparam int EIS_TXS_LEVEL_LSB = 16;
    localparam int EIS_RXS_LEVEL_LSB = 0;
    localparam int EIS_LEVEL_W = 8;

    // Fixed values
    localparam logic [31:0] EIS_BYTE_TEST_VALUE = 32'h8765_4321;
    localparam logic [31:0] EIS_DROP_MIDPOINT = 32'h8000_0000;
    localparam logic [15:0] EIS_TIMER_ZERO = 16'h0000;
    localparam logic [15:0] EIS_TIMER_WRAP = 16'hFFFF;
    localparam logic [15:0] EIS_OVERSIZE_LIMIT = 16'h0800;

    // Event sources from the rest of the controller, all on clk
    typedef struct packed {
        logic tx_stop_request;
        logic tx_halted;
        logic rx_halted;
        logic [31:0] drop_count;
        logic buffer_loaded;
        logic interrupt_on_completion;
        logic rx_dma_done;
        logic [15:0] timer_value;
        logic transceiver_event;
        logic power_event;
        logic tx_status_overflow;
        logic rx_frame_end;
        logic [15:0] rx_frame_length;
        logic rx_error;
        logic tx_error;
        logic tx_data_write;
        logic tx_data_full;
        logic [7:0] tx_free_blocks;
        logic tx_status_full;
        logic [7:0] tx_status_used;
        logic frame_dropped;
        logic rx_status_full;
        logic [7:0] rx_status_used;
        logic [2:0] pin_events;
    } eis_events_t;

    // Host bus pins as seen by the device
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [31:0] data_in;
    } eis_host_pins_t;

endpackage

// ---- src/eis_sticky_flag.sv ----
`timescale 1ns/1ps
`default_nettype none

module eis_sticky_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set_event,
    input wire logic clear,
    output logic flag
);

    logic flag_reg;

    // Set beats a clear in the same cycle so no event is lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= set_event | (flag_reg & ~clear);
        end
    end

    assign flag = flag_reg;

endmodule

`default_nettype wire

// ---- src/eis_status_block.sv ----
// Operation
// - Enabling the software event sets bit 31; writing one clears it.
// - Bit 25 sets when transmit stop is requested and transmitter halted.
// - Bit 24 sets when the receive engine halts.
// - Bit 23 sets when drop counter steps onto 80000000h.
// - Bit 21 sets when a completion-flagged transmit buffer is loaded.
// - Bit 20 sets when the receive DMA count has been moved.
// - Bit 19 sets when the timer wraps from zero to FFFFh.
// - Bit 18 is read-only, follows transceiver event; writes ignored.
// - Bit 17 sets on a detected power management event.
// - Power bit works and clears regardless of wake output state.
// - Power event never wakes; only a byte-test write wakes.
// - Hold-off interval never delays the power interrupt.
// - Bit 16 sets when the transmit status FIFO overflows.
// - Bit 15 sets on a received packet over 2048 bytes.
// - Bit 14 on receive errors, bit 13 on transmit errors.
// - Bit 10 sets on a transmit data write while that FIFO is full.
// - Bit 9 sets while transmit free space exceeds its threshold.
// - Bit 8 on transmit status full, bit 4 on receive status full.
// - Bits 7 and 3 set when status FIFO occupancy passes thresholds.
// - Bit 6 sets each time a receive frame is dropped.
// - Bits 2 to 0 capture pin events, each cleared by a one.
// - Status bits other than bit 31 record events whatever the enable mask holds.
// - Master interrupt is high while any enabled status bit is set.
`timescale 1ns/1ps
`default_nettype none

module eis_status_block (
    input wire logic clk,
    input wire logic rst_n,
    input wire eis_pkg::eis_host_pins_t host_pins,
    input wire eis_pkg::eis_events_t events,
    input wire logic wake_output_enable,
    output logic [31:0] bus_rdata,
    output logic bus_rdata_oe_n,
    output logic master_irq,
    output logic wake_request,
    output logic wake_event_output
);
    import eis_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Host bus synchronisers and strobe edges

    eis_host_pins_t pins_meta_reg;
    eis_host_pins_t pins_sync_reg;
    logic wr_prev_reg;
    logic rd_prev_reg;
    logic wr_active;
    logic rd_active;
    logic wr_start;
    logic rd_start;

    // Pins are asynchronous to clk; two stages before any use
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_meta_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                               addr: '0, data_in: '0};
            pins_sync_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                               addr: '0, data_in: '0};
        end else begin
            pins_meta_reg <= host_pins;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    // Strobe levels and their leading edges
    assign wr_active = ~pins_sync_reg.cs_n & ~pins_sync_reg.wr_n;
    assign rd_active = ~pins_sync_reg.cs_n & ~pins_sync_reg.rd_n;
    assign wr_start = wr_active & ~wr_prev_reg;
    assign rd_start = rd_active & ~rd_prev_reg;

    // One access per strobe assertion, however long the host holds it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_prev_reg <= 1'b0;
            rd_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg <= wr_active;
            rd_prev_reg <= rd_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers: enable mask and FIFO levels

    logic [31:0] enable_reg;
    logic [31:0] fifo_level_reg;
    logic wr_status;
    logic wr_enable;
    logic wr_fifo_level;
    logic wr_byte_test;

    // Write decode, one pulse per access
    assign wr_status = wr_start & (pins_sync_reg.addr == EIS_OFS_STATUS);
    assign wr_enable = wr_start & (pins_sync_reg.addr == EIS_OFS_ENABLE);
    assign wr_fifo_level = wr_start &
                           (pins_sync_reg.addr == EIS_OFS_FIFO_LEVEL);
    assign wr_byte_test = wr_start &
                          (pins_sync_reg.addr == EIS_OFS_BYTE_TEST);

    // Reserved bits of both registers are held at zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_reg <= EIS_ZERO_WORD;
            fifo_level_reg <= EIS_FIFO_LEVEL_RESET;
        end else begin
            if (wr_enable) begin
                enable_reg <= pins_sync_reg.data_in & EIS_ENABLE_MASK;
            end
            if (wr_fifo_level) begin
                fifo_level_reg <= pins_sync_reg.data_in & EIS_FIFO_LEVEL_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Previous values for the edge-type sources

    logic sw_enable_prev_reg;
    logic tx_stopped_prev_reg;
    logic rx_halted_prev_reg;
    logic [31:0] drop_prev_reg;
    logic [15:0] timer_prev_reg;
    logic txs_full_prev_reg;
    logic rxs_full_prev_reg;
    logic transceiver_reg;
    logic tx_stopped;

    assign tx_stopped = events.tx_stop_request & events.tx_halted;

    // Halt, full and software sources fire once per rising edge, so a clear sticks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_enable_prev_reg <= 1'b0;
            tx_stopped_prev_reg <= 1'b0;
            rx_halted_prev_reg <= 1'b0;
            drop_prev_reg <= EIS_ZERO_WORD;
            timer_prev_reg <= EIS_TIMER_ZERO;
            txs_full_prev_reg <= 1'b0;
            rxs_full_prev_reg <= 1'b0;
        end else begin
            sw_enable_prev_reg <= enable_reg[EIS_BIT_SOFTWARE];
            tx_stopped_prev_reg <= tx_stopped;
            rx_halted_prev_reg <= events.rx_halted;
            drop_prev_reg <= events.drop_count;
            timer_prev_reg <= events.timer_value;
            txs_full_prev_reg <= events.tx_status_full;
            rxs_full_prev_reg <= events.rx_status_full;
        end
    end

    // Transceiver bit mirrors its source, never latched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            transceiver_reg <= 1'b0;
        end else begin
            transceiver_reg <= events.transceiver_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set conditions per status bit; the mask is consulted here only for bit 31

    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic [31:0] flag_vec;
    logic [31:0] status_word;

    always_comb begin
        set_vec = EIS_ZERO_WORD;
        set_vec[EIS_BIT_SOFTWARE] = enable_reg[EIS_BIT_SOFTWARE] &
                                    ~sw_enable_prev_reg;
        set_vec[EIS_BIT_TX_HALTED] = tx_stopped &
                                     ~tx_stopped_prev_reg;
        set_vec[EIS_BIT_RX_HALTED] = events.rx_halted &
                                     ~rx_halted_prev_reg;
        set_vec[EIS_BIT_DROP_MID] = (events.drop_count == EIS_DROP_MIDPOINT) &
            (drop_prev_reg != EIS_DROP_MIDPOINT);
        set_vec[EIS_BIT_BUF_LOADED] = events.buffer_loaded &
                                      events.interrupt_on_completion;
        set_vec[EIS_BIT_RX_DMA] = events.rx_dma_done;
        set_vec[EIS_BIT_TIMER_WRAP] = (timer_prev_reg == EIS_TIMER_ZERO) &
            (events.timer_value == EIS_TIMER_WRAP);
        // Power bit ignores the wake output enable entirely
        set_vec[EIS_BIT_POWER] = events.power_event;
        set_vec[EIS_BIT_TXS_OVERFLOW] = events.tx_status_overflow;
        set_vec[EIS_BIT_OVERSIZE] = events.rx_frame_end &
                                    (events.rx_frame_length >
                                     EIS_OVERSIZE_LIMIT);
        set_vec[EIS_BIT_RX_ERROR] = events.rx_error;
        set_vec[EIS_BIT_TX_ERROR] = events.tx_error;
        set_vec[EIS_BIT_TXD_OVERRUN] = events.tx_data_write &
                                       events.tx_data_full;
        set_vec[EIS_BIT_TXD_AVAIL] = events.tx_free_blocks >
            fifo_level_reg[EIS_TXD_AVAIL_LSB +: EIS_LEVEL_W];
        set_vec[EIS_BIT_TXS_FULL] = events.tx_status_full &
                                    ~txs_full_prev_reg;
        set_vec[EIS_BIT_RXS_FULL] = events.rx_status_full &
                                    ~rxs_full_prev_reg;
        set_vec[EIS_BIT_TXS_LEVEL] = events.tx_status_used >
            fifo_level_reg[EIS_TXS_LEVEL_LSB +: EIS_LEVEL_W];
        set_vec[EIS_BIT_RXS_LEVEL] = events.rx_status_used >
            fifo_level_reg[EIS_RXS_LEVEL_LSB +: EIS_LEVEL_W];
        set_vec[EIS_BIT_FRAME_DROP] = events.frame_dropped;
        set_vec[EIS_BIT_PIN_LSB +: EIS_PIN_COUNT] = events.pin_events;
    end

    // Only ones in writable positions clear; zeros leave bits alone
    assign clear_vec = {32{wr_status}} & pins_sync_reg.data_in &
                       EIS_W1C_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Sticky status flags, one per clearable bit

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            if (EIS_W1C_MASK[gi]) begin : g_sticky
                eis_sticky_flag u_flag (
                    .clk(clk),
                    .rst_n(rst_n),
                    .set_event(set_vec[gi]),
                    .clear(clear_vec[gi]),
                    .flag(flag_vec[gi])
                );
            end else begin : g_none
                assign flag_vec[gi] = 1'b0;
            end
        end
    endgenerate

    // Reserved positions stay zero; transceiver bit joins here
    always_comb begin
        status_word = flag_vec & EIS_STATUS_MASK;
        status_word[EIS_BIT_TRANSCEIVER] = transceiver_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and pin drive

    logic [31:0] rdata_next;
    logic [31:0] bus_rdata_reg;
    logic bus_rdata_oe_n_reg;

    // Read mux; unmapped offsets read as zero
    always_comb begin
        case (pins_sync_reg.addr)
            EIS_OFS_STATUS: rdata_next = status_word;
            EIS_OFS_ENABLE: rdata_next = enable_reg;
            EIS_OFS_BYTE_TEST: rdata_next = EIS_BYTE_TEST_VALUE;
            EIS_OFS_FIFO_LEVEL: rdata_next = fifo_level_reg;
            default: rdata_next = EIS_ZERO_WORD;
        endcase
    end

    // Data captured at strobe start; stays stable through the cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_rdata_reg <= EIS_ZERO_WORD;
            bus_rdata_oe_n_reg <= 1'b1;
        end else begin
            if (rd_start) begin
                bus_rdata_reg <= rdata_next;
            end
            bus_rdata_oe_n_reg <= ~rd_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master interrupt, wake request and wake output

    logic master_irq_reg;
    logic wake_request_reg;
    logic wake_event_reg;

    // No hold-off here, so the power bit reaches the line undelayed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            master_irq_reg <= 1'b0;
        end else begin
            master_irq_reg <= |(status_word & enable_reg);
        end
    end

    // Waking is tied to the byte-test write alone, not to power events
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_request_reg <= 1'b0;
        end else begin
            wake_request_reg <= wr_byte_test;
        end
    end

    // Wake pin follows the power bit only while enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_event_reg <= 1'b0;
        end else begin
            wake_event_reg <= wake_output_enable &
                              status_word[EIS_BIT_POWER];
        end
    end

    // Ports come straight from their flops
    assign bus_rdata = bus_rdata_reg;
    assign bus_rdata_oe_n = bus_rdata_oe_n_reg;
    assign master_irq = master_irq_reg;
    assign wake_request = wake_request_reg;
    assign wake_event_output = wake_event_reg;

endmodule

`default_nettype wire

// ---- testbench/eis_status_block_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module eis_status_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire eis_pkg::eis_host_pins_t host_pins,
    input wire eis_pkg::eis_events_t events,
    input wire logic wake_output_enable,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_rdata_oe_n,
    input wire logic master_irq,
    input wire logic wake_request,
    input wire logic wake_event_output
);
    import eis_pkg::*;
    logic en_seen_reg;
    logic en17_reg;
    logic en31_reg;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////
    // Start of a host access on the raw pins
    sequence wr_at(logic [7:0] a);
        $fell(host_pins.wr_n) && !host_pins.cs_n && host_pins.addr == a;
    endsequence
    sequence rd_at(logic [7:0] a);
        $fell(host_pins.rd_n) && !host_pins.cs_n && host_pins.addr == a;
    endsequence

    // Shadow of the mask; raw pins lead the design copy, never lag it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_seen_reg <= 1'b0;
            en17_reg <= 1'b0;
            en31_reg <= 1'b0;
        end else if ($fell(host_pins.wr_n) && !host_pins.cs_n
                     && host_pins.addr == EIS_OFS_ENABLE) begin
            en_seen_reg <= 1'b1;
            en17_reg <= host_pins.data_in[EIS_BIT_POWER];
            en31_reg <= host_pins.data_in[EIS_BIT_SOFTWARE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    AST_IRQ_QUIET: assert property (!en_seen_reg |-> !master_irq)
        else $error("irq without any enabled source");
    AST_SW_IRQ: assert property ((!en31_reg && host_pins.data_in[31]) ##0
        wr_at(EIS_OFS_ENABLE) |-> ##[3:6] master_irq)
        else $error("software event did not raise irq");
    AST_PWR_IRQ: assert property (en17_reg && host_pins.wr_n
        && $past(host_pins.wr_n, 4) && events.power_event
        |-> ##[1:3] master_irq) else $error("power irq delayed");
    AST_WAKE_GATE: assert property (!wake_output_enable
        |=> !wake_event_output) else $error("wake output not gated");
    AST_WAKE_FOLLOW: assert property (wake_output_enable
        && events.power_event ##1 wake_output_enable [*2]
        |-> wake_event_output) else $error("wake output missing");
    AST_NO_SPURIOUS_WAKE: assert property (host_pins.wr_n [*5]
        |-> !wake_request) else $error("wake without host write");
    AST_WAKE_PULSE: assert property (wake_request |=> !wake_request)
        else $error("wake request longer than one cycle");
    AST_BYTE_TEST: assert property (rd_at(EIS_OFS_BYTE_TEST) |->
        ##[2:4] (!bus_rdata_oe_n && bus_rdata == EIS_BYTE_TEST_VALUE))
        else $error("byte test read wrong");
    AST_RESV_ZERO: assert property (rd_at(EIS_OFS_STATUS) |->
        ##[2:4] (!bus_rdata_oe_n
        && (bus_rdata & ~EIS_STATUS_MASK) == EIS_ZERO_WORD))
        else $error("reserved status bit set");
endmodule

bind eis_status_block eis_status_checker eis_status_checker_i (
    .clk, .rst_n, .host_pins, .events, .wake_output_enable, .bus_rdata,
    .bus_rdata_oe_n, .master_irq, .wake_request, .wake_event_output
);
`default_nettype wire

// ---- testbench/eis_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eis_host_model (
    input wire logic clk,
    output var eis_pkg::eis_host_pins_t pins
);
    import eis_pkg::*;

    // Idle bus, strobes high
    initial pins = '1;

    // One whole access; address settles three cycles before the strobe
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge clk);
        pins.addr <= a;
        pins.data_in <= w ? d : ~pins.data_in;
        repeat (3) @(posedge clk);
        pins.cs_n <= 1'b0;
        pins.rd_n <= w;
        pins.wr_n <= !w;
        repeat (5) @(posedge clk);
        pins.cs_n <= 1'b1;
        pins.rd_n <= 1'b1;
        pins.wr_n <= 1'b1;
        pins.data_in <= ~d;  // Released lines carry no stale word
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eis_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    eis_host_pins_t host_pins;
    eis_events_t ev = '0;
    logic wake_en = 1'b0;
    logic [31:0] bus_rdata;
    logic bus_rdata_oe_n, master_irq, wake_request, wake_event_output;
    logic oe_prev = 1'b1;
    logic [31:0] seed = 32'h0000_3F34;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int check_count = 0;
    int wake_count = 0;
    logic [7:0] reg_ofs[5] = '{EIS_OFS_STATUS, EIS_OFS_ENABLE,
        EIS_OFS_FIFO_LEVEL, EIS_OFS_BYTE_TEST, 8'h70};
    logic [31:0] reg_rst[5] = '{EIS_ZERO_WORD, EIS_ZERO_WORD,
        EIS_FIFO_LEVEL_RESET, EIS_BYTE_TEST_VALUE, EIS_ZERO_WORD};
    // Codes 40 and 41 sit exactly on a limit and must not set
    int ev_code[23] = '{25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10,
        9, 8, 7, 6, 4, 3, 2, 1, 0, 40, 41};

    always #25 clk = ~clk;

    eis_host_model eis_host_model_i (.clk, .pins(host_pins));
    eis_status_block eis_status_block_i (.clk, .rst_n, .host_pins,
        .events(ev), .wake_output_enable(wake_en), .bus_rdata,
        .bus_rdata_oe_n, .master_irq, .wake_request, .wake_event_output);

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check_rd(input logic [31:0] e);
        check_count++;
        if (bus_rdata !== e) begin
            fail_count++;
            $display("Error %0t: read %h expected %h", $time, bus_rdata, e);
        end
    endtask

    task automatic check_bit(input logic got, input logic e);
        #1;
        check_count++;
        if (got !== e) begin
            fail_count++;
            $display("Error %0t: flag %b expected %b", $time, got, e);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        eis_host_model_i.access(1'b0, a, EIS_ZERO_WORD);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        eis_host_model_i.access(1'b1, a, d);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    // Two-step source stimulus; most codes need only the second step
    task automatic fire(input int b);
        eis_events_t a;
        eis_events_t c;
        a = '0;
        c = '0;
        case (b)
            25: begin
                a.tx_stop_request = 1'b1;
                c = a;
                c.tx_halted = 1'b1;
            end
            24: c.rx_halted = 1'b1;
            23: begin
                a.drop_count = 32'h7FFF_FFFF;
                c.drop_count = EIS_DROP_MIDPOINT;
            end
            21: c.buffer_loaded = 1'b1;
            20: c.rx_dma_done = 1'b1;
            19: c.timer_value = EIS_TIMER_WRAP;
            17: c.power_event = 1'b1;
            16: c.tx_status_overflow = 1'b1;
            15: c.rx_frame_length = 16'h0801 + 16'(rnd() % 32'h0000_0FA0);
            14: c.rx_error = 1'b1;
            13: c.tx_error = 1'b1;
            10: c.tx_data_write = 1'b1;
            9: c.tx_free_blocks = 8'h49;
            8: c.tx_status_full = 1'b1;
            7: c.tx_status_used = 8'h01;
            6: c.frame_dropped = 1'b1;
            4: c.rx_status_full = 1'b1;
            3: c.rx_status_used = 8'h01;
            40: c.rx_frame_length = EIS_OVERSIZE_LIMIT;
            41: c.tx_free_blocks = 8'h48;
            default: c.pin_events[b[1:0]] = 1'b1;
        endcase
        c.interrupt_on_completion = (b == 21);
        c.tx_data_full = (b == 10);
        c.rx_frame_end = (b == 15) || (b == 40);
        @(posedge clk);
        ev <= a;
        @(posedge clk);
        ev <= c;
        @(posedge clk);
        ev <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Read data is judged when the device starts driving the pins
    always @(posedge clk) begin
        #1;
        if (bus_rdata_oe_n === 1'b0 && oe_prev === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("Error %0t: data driven with no read pending", $time);
            end else begin
                check_rd(exp_q.pop_front());
            end
        end
        if (wake_request === 1'b1) begin
            wake_count++;
        end
        oe_prev = bus_rdata_oe_n;
    end

    task automatic results();
        // A read that never drove the pins is a miss, not a pass
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("Error %0t: %0d reads unanswered", $time, exp_q.size());
        end
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 1350 cycles the run needs
    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        $display("Error %0t: watchdog expired", $time);
        results();
    end

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (reg_ofs[i]) begin
            rd(reg_ofs[i], reg_rst[i]);
        end
        r = rnd();
        wr(EIS_OFS_FIFO_LEVEL, r);
        rd(EIS_OFS_FIFO_LEVEL, r & EIS_FIFO_LEVEL_MASK);
        wr(EIS_OFS_FIFO_LEVEL, EIS_FIFO_LEVEL_RESET);
        done("registers");
        wr(EIS_OFS_ENABLE, 32'hFFFF_FFFF);
        rd(EIS_OFS_ENABLE, EIS_ENABLE_MASK);
        rd(EIS_OFS_STATUS, 32'h8000_0000);
        check_bit(master_irq, 1'b1);
        wr(EIS_OFS_STATUS, EIS_ZERO_WORD);
        rd(EIS_OFS_STATUS, 32'h8000_0000);
        wr(EIS_OFS_STATUS, 32'h8000_0000);
        rd(EIS_OFS_STATUS, EIS_ZERO_WORD);
        check_bit(master_irq, 1'b0);
        wr(EIS_OFS_ENABLE, 32'h0002_0000);
        done("software");
        foreach (ev_code[i]) begin
            r = (ev_code[i] < 32) ? 32'h0000_0001 << ev_code[i]
                                  : EIS_ZERO_WORD;
            fire(ev_code[i]);
            rd(EIS_OFS_STATUS, r);
            wr(EIS_OFS_STATUS, r);
            rd(EIS_OFS_STATUS, EIS_ZERO_WORD);
        end
        done("sources");
        @(posedge clk);
        ev.transceiver_event <= 1'b1;
        rd(EIS_OFS_STATUS, 32'h0004_0000);
        wr(EIS_OFS_STATUS, 32'h0004_0000);
        rd(EIS_OFS_STATUS, 32'h0004_0000);
        @(posedge clk);
        ev.transceiver_event <= 1'b0;
        rd(EIS_OFS_STATUS, EIS_ZERO_WORD);
        // Drop lands on the very edge where the clearing write commits
        fork
            wr(EIS_OFS_STATUS, 32'h0000_0040);
            begin
                repeat (6) @(posedge clk);
                ev.frame_dropped <= 1'b1;
                @(posedge clk);
                ev.frame_dropped <= 1'b0;
            end
        join
        rd(EIS_OFS_STATUS, 32'h0000_0040);
        wr(EIS_OFS_STATUS, 32'h0000_0040);
        done("status");
        fire(17);
        check_bit(wake_event_output, 1'b0);
        @(posedge clk);
        wake_en <= 1'b1;
        repeat (3) @(posedge clk);
        check_bit(wake_event_output, 1'b1);
        wr(EIS_OFS_STATUS, 32'h0002_0000);
        rd(EIS_OFS_STATUS, EIS_ZERO_WORD);
        check_bit(wake_event_output, 1'b0);
        fire(17);
        wr(EIS_OFS_STATUS, 32'h0002_0000);
        @(posedge clk);
        wake_en <= 1'b0;
        check_bit(wake_count == 0, 1'b1);
        wr(EIS_OFS_BYTE_TEST, rnd());
        rd(EIS_OFS_BYTE_TEST, EIS_BYTE_TEST_VALUE);
        check_bit(wake_count == 1, 1'b1);
        done("power");
        results();
    end
endmodule
`default_nettype wire
